// File: dv/converter_ctrl_chk.sv
// Port assertions for the converter control block.
// Assumes one clock domain and the package addresses.
`timescale 1ns/100ps
module converter_ctrl_chk (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic timer2_overflow,
  input wire logic timer3_overflow,
  input wire logic external_convert_start,
  input wire logic [11:0] sar_code,
  input wire logic converter_powered,
  input wire logic burst_clock_select,
  input wire logic sample_hold,
  input wire logic window_match_flag,
  input wire logic conversion_done_flag
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  logic ctl_wr;
  assign ctl_wr = sfr_wr && sfr_addr == converter_pkg::CONTROL_ADDR;
  enable_follows_a: assert property
    (ctl_wr |=> converter_powered == $past(sfr_wdata[converter_pkg::ENABLE_BIT]))
    else $error("enable output does not follow control write");
  burst_follows_a: assert property
    (ctl_wr |=> burst_clock_select == $past(sfr_wdata[converter_pkg::BURST_BIT]))
    else $error("burst select does not follow control write");
  off_idle_a: assert property (!converter_powered |-> !sample_hold)
    else $error("conversion while shut down");
  conv_length_a: assert property ($rose(sample_hold) |-> ##53 sample_hold)
    else $error("conversion shorter than 54 cycles");
  series_end_a: assert property ($rose(sample_hold) |-> ##[54:900] !sample_hold)
    else $error("series does not end in time");
  done_on_end_a: assert property
    ($fell(sample_hold) && converter_powered |-> ##[0:2] conversion_done_flag)
    else $error("done flag not set at end");
  done_sticky_a: assert property
    (conversion_done_flag && !ctl_wr |=> conversion_done_flag)
    else $error("done flag dropped without write");
  window_sticky_a: assert property
    (window_match_flag && !ctl_wr |=> window_match_flag)
    else $error("window flag dropped without write");
  cover property ($fell(sample_hold));
  cover property (conversion_done_flag && window_match_flag);
  cover property (burst_clock_select && sample_hold);
endmodule // converter_ctrl_chk
bind converter_ctrl converter_ctrl_chk converter_ctrl_chk_inst (.sys_clk(sys_clk), .rst_b(rst_b),
  .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_rdata(sfr_rdata), .timer2_overflow(timer2_overflow), .timer3_overflow(timer3_overflow),
  .external_convert_start(external_convert_start), .sar_code(sar_code),
  .converter_powered(converter_powered), .burst_clock_select(burst_clock_select),
  .sample_hold(sample_hold), .window_match_flag(window_match_flag),
  .conversion_done_flag(conversion_done_flag));

// File: dv/tb_top.sv
// Self-checking bench for the converter control block.
// Assumes the SAR code is held steady for a whole series.
`timescale 1ns/100ps
module tb_top;
  logic sys_clk, rst_b, sfr_wr, sfr_rd, pwr, bst, hold, win, done, rd_d;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic [11:0] sar_code;
  logic [2:0] trig;
  logic [15:0] lo_b, up_b;
  logic [15:0] expq[$];
  logic [11:0] wcode[6] = '{12'h100, 12'h101, 12'h1FF, 12'h200, 12'h050, 12'h250};
  int err_count, n_tests, seed, hold_cycles;
  converter_ctrl converter_ctrl_inst (.sys_clk(sys_clk), .rst_b(rst_b), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .timer2_overflow(trig[2]), .timer3_overflow(trig[0]), .external_convert_start(trig[1]),
    .sar_code(sar_code), .converter_powered(pwr), .burst_clock_select(bst),
    .sample_hold(hold), .window_match_flag(win), .conversion_done_flag(done));
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp(string name, logic [15:0] exp, logic [15:0] seen);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge sys_clk);
    sfr_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    expq.push_back({a, e});
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge sys_clk);
    sfr_rd <= 1'b0;
    @(posedge sys_clk);
  endtask
  // Read data stands one cycle after the strobe
  always @(posedge sys_clk) rd_d <= sfr_rd;
  always @(negedge sys_clk)
    if (rd_d === 1'b1)
    begin
      n_tests++;
      if (sfr_rdata !== expq[0][7:0])
      begin
        err_count++;
        $display("unexpected read %h expected %h seen %h", expq[0][15:8], expq[0][7:0], sfr_rdata);
      end
      void'(expq.pop_front());
    end
  // Cycles spent converting, cleared by each conversion call
  always @(negedge sys_clk)
    if (hold === 1'b1)
      hold_cycles++;
  task automatic conv(logic [7:0] cfg, logic [7:0] ctl, logic [11:0] code);
    int n, i;
    logic [15:0] res;
    logic [15:0] exp_hold;
    logic hit;
    n = (cfg[1:0] == 2'h0) ? 1 : (2 << cfg[1:0]);
    res = ctl[2] ? {code, 4'h0} : 16'(code * n);
    hit = cfg[2] ? (res < lo_b || res > up_b) : (res > lo_b && res < up_b);
    exp_hold = 16'(n * converter_pkg::CONVERT_CYCLES);
    sar_code <= code;
    hold_cycles = 0;
    wr(8'hBC, cfg);
    wr(8'hE8, ctl);
    if (ctl[1:0] == 2'h0)
      wr(8'hE8, ctl | 8'h10);
    else
    begin
      trig <= 3'h1 << (ctl[1:0] - 2'h1);
      repeat ((ctl[1:0] == 2'h2) ? 4 : 1) @(posedge sys_clk);
      trig <= 3'h0;
    end
    for (i = 0; i < 1000 && done !== 1'b1; i++)
      @(negedge sys_clk);
    if (i == 1000)
    begin
      err_count++;
      report_and_stop();
    end
    else
    begin
      cmp("sample_hold cycles", exp_hold, 16'(hold_cycles));
      cmp("window_match_flag", {15'h0, hit}, {15'h0, win});
      cmp("converter_powered", {15'h0, ctl[7]}, {15'h0, pwr});
      cmp("burst_clock_select", {15'h0, ctl[6]}, {15'h0, bst});
      @(posedge sys_clk);
      rd(8'hE8, {ctl[7:6], 2'b10, hit, ctl[2:0]});
      rd(8'hBE, res[15:8]);
      rd(8'hBD, res[7:0]);
      wr(8'hE8, ctl);
      cmp("conversion_done_flag", 16'h0000, {15'h0, done});
    end
  endtask
  initial
  begin
    #400000;
    err_count++;
    report_and_stop();
  end
  initial
  begin
    seed = 32'hF4A6;
    rst_b = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    trig = 3'h0;
    sar_code = 12'h000;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    rd(8'hE8, 8'h00);
    rd(8'hC6, 8'hFF);
    rd(8'hC5, 8'hFF);
    rd(8'hC4, 8'h00);
    rd(8'hBC, 8'h00);
    rd(8'hC3, 8'h00);
    rd(8'hBE, 8'h00);
    rd(8'hBD, 8'h00);
    rd(8'h00, 8'h00);
    wr(8'hE8, 8'h10);
    repeat (60) @(posedge sys_clk);
    rd(8'hE8, 8'h00);
    lo_b = 16'h0000;
    up_b = 16'hFFFF;
    for (int r = 0; r < 4; r++)
      conv(8'(r), 8'h80 | 8'(r), 12'($random(seed)));
    conv(8'h03, 8'h80, 12'hFFF);
    conv(8'h00, 8'h84, 12'hFFF);
    conv(8'h00, 8'hC4, 12'($random(seed)));
    lo_b = 16'h0100;
    up_b = 16'h0200;
    wr(8'hC4, 8'h01);
    wr(8'hC3, 8'h00);
    wr(8'hC6, 8'h02);
    wr(8'hC5, 8'h00);
    for (int m = 0; m < 2; m++)
      foreach (wcode[k])
        conv(m ? 8'h04 : 8'h00, 8'h80, wcode[k]);
    // Abort a 16-sample series by clearing enable
    wr(8'hBC, 8'h03);
    wr(8'hE8, 8'h90);
    repeat (100) @(posedge sys_clk);
    wr(8'hE8, 8'h00);
    cmp("sample_hold after abort", 16'h0000, {15'h0, hold});
    rd(8'hE8, 8'h00);
    report_and_stop();
  end
endmodule // tb_top

// File: rtl/converter_ctrl.sv
// Control, result and window logic of a 12-bit converter.
// Assumes an analog core answering each sample request with sar_code.
//
// Summary of operation
// [R1] Single conversion refreshes 12-bit unsigned result
// [R2] Justify select chooses right or left alignment
// [R3] Unused result bits read as zero
// [R4] Series result updated once after last conversion
// [R5] Repeat field selects 1, 4, 8 or 16
// [R6] Software keeps right justify when accumulating
// [R7] Bit 7 enables converter, else shutdown
// [R8] Bit 6 enables burst mode
// [R9] Burst mode selects burst oscillator clock
// [R10] Conversion lasts 13 SAR periods plus 2
// [R11] Inside window: lower < result < upper
// [R12] Outside window: result below lower or above upper
// [R13] Done flag when active falls at series end, not on abort; flags sticky
// [R14] Start source selects write, timers or pin
`timescale 1ns/100ps
module converter_ctrl (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  input wire logic timer2_overflow,
  input wire logic timer3_overflow,
  input wire logic external_convert_start,
  input wire logic [11:0] sar_code,
  output logic converter_powered,
  output logic burst_clock_select,
  output logic sample_hold,
  output logic window_match_flag,
  output logic conversion_done_flag
);
  typedef enum logic [1:0] {IDLE, CONVERT, FINISH} phase_t;
  typedef struct packed {
    phase_t phase;
    logic [7:0] control_reg;
    logic [7:0] config_reg;
    logic [15:0] result_reg;
    logic [15:0] lower_reg;
    logic [15:0] upper_reg;
    logic [7:0] cycle_reg;
    logic [4:0] count_reg;
    logic pin_meta_reg;
    logic pin_sync_reg;
    logic pin_prev_reg;
    logic [7:0] rdata_reg;
  } ctrl_state_t;
  ctrl_state_t st_reg;
  ctrl_state_t st_next;
  logic [15:0] acc_sum;
  logic acc_clear;
  logic acc_add;
  logic [4:0] series_len;
  logic start_event;
  logic [15:0] new_result;
  logic in_window;
  logic out_window;
  logic [15:0] final_sum;

  sample_sum u_sum (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clear(acc_clear),
    .add(acc_add),
    .sample(sar_code),
    .sum(acc_sum)
  );

  always_comb
  begin
    case (st_reg.config_reg[1:0]) // see [R5]
      converter_pkg::REPEAT_1: series_len = 5'd1;
      converter_pkg::REPEAT_4: series_len = 5'd4;
      converter_pkg::REPEAT_8: series_len = 5'd8;
      default: series_len = 5'd16;
    endcase
    case (st_reg.control_reg[1:0]) // see [R14]
      converter_pkg::START_WRITE: start_event = sfr_wr &&
        sfr_addr == converter_pkg::CONTROL_ADDR && sfr_wdata[converter_pkg::ACTIVE_BIT];
      converter_pkg::START_TIMER3: start_event = timer3_overflow;
      converter_pkg::START_PIN: start_event = st_reg.pin_sync_reg && !st_reg.pin_prev_reg;
      default: start_event = timer2_overflow;
    endcase
  end

  assign acc_clear = st_reg.phase == IDLE;
  assign acc_add = st_reg.phase == CONVERT &&
    st_reg.cycle_reg == 8'(converter_pkg::CONVERT_CYCLES - 1);
  assign final_sum = acc_sum + {4'h0, sar_code};

  always_comb
  begin
    // Right justify unless single shot with left select; see [R2] [R3] [R6]
    if (series_len == 5'd1)
    begin
      if (st_reg.control_reg[converter_pkg::JUSTIFY_BIT])
        new_result = {sar_code, 4'h0};
      else
        new_result = {4'h0, sar_code}; // see [R1]
    end
    else
      new_result = final_sum; // see [R4]
  end

  always_comb
  begin
    st_next = st_reg;
    st_next.pin_meta_reg = external_convert_start;
    st_next.pin_sync_reg = st_reg.pin_meta_reg;
    st_next.pin_prev_reg = st_reg.pin_sync_reg;
    st_next.rdata_reg = 8'h00;
    if (sfr_rd)
    begin
      case (sfr_addr)
        converter_pkg::CONTROL_ADDR: st_next.rdata_reg = st_reg.control_reg;
        converter_pkg::CONFIG_ADDR: st_next.rdata_reg = st_reg.config_reg;
        converter_pkg::RESULT_HI_ADDR: st_next.rdata_reg = st_reg.result_reg[15:8];
        converter_pkg::RESULT_LO_ADDR: st_next.rdata_reg = st_reg.result_reg[7:0];
        converter_pkg::LOWER_HI_ADDR: st_next.rdata_reg = st_reg.lower_reg[15:8];
        converter_pkg::LOWER_LO_ADDR: st_next.rdata_reg = st_reg.lower_reg[7:0];
        converter_pkg::UPPER_HI_ADDR: st_next.rdata_reg = st_reg.upper_reg[15:8];
        converter_pkg::UPPER_LO_ADDR: st_next.rdata_reg = st_reg.upper_reg[7:0];
        default: st_next.rdata_reg = 8'h00;
      endcase
    end
    if (sfr_wr)
    begin
      case (sfr_addr)
        converter_pkg::CONTROL_ADDR:
        begin
          // Active bit is hardware owned; writing 1 only triggers
          st_next.control_reg = {sfr_wdata[7:5],
            st_reg.control_reg[converter_pkg::ACTIVE_BIT], sfr_wdata[3:0]};
        end
        converter_pkg::CONFIG_ADDR: st_next.config_reg = sfr_wdata;
        converter_pkg::LOWER_HI_ADDR: st_next.lower_reg[15:8] = sfr_wdata;
        converter_pkg::LOWER_LO_ADDR: st_next.lower_reg[7:0] = sfr_wdata;
        converter_pkg::UPPER_HI_ADDR: st_next.upper_reg[15:8] = sfr_wdata;
        converter_pkg::UPPER_LO_ADDR: st_next.upper_reg[7:0] = sfr_wdata;
        default: st_next.config_reg = st_reg.config_reg;
      endcase
    end
    case (st_reg.phase)
      IDLE:
      begin
        if (start_event && st_reg.control_reg[converter_pkg::ENABLE_BIT]) // see [R7]
        begin
          st_next.phase = CONVERT;
          st_next.cycle_reg = 8'h00;
          st_next.count_reg = 5'h00;
          st_next.control_reg[converter_pkg::ACTIVE_BIT] = 1'b1;
        end
      end
      CONVERT:
      begin
        // 13 SAR periods plus 2 start/finish cycles; see [R10]
        if (st_reg.cycle_reg == 8'(converter_pkg::CONVERT_CYCLES - 1))
        begin
          st_next.cycle_reg = 8'h00;
          st_next.count_reg = st_reg.count_reg + 5'd1;
          if (st_reg.count_reg + 5'd1 == series_len)
            st_next.phase = FINISH;
        end
        else
          st_next.cycle_reg = st_reg.cycle_reg + 8'd1;
        if (acc_add && st_reg.count_reg + 5'd1 == series_len)
          st_next.result_reg = new_result; // see [R1] [R4]
      end
      FINISH:
      begin
        st_next.phase = IDLE;
        // Active falls; done and window set win over a same-cycle clear
        st_next.control_reg[converter_pkg::ACTIVE_BIT] = 1'b0;
        st_next.control_reg[converter_pkg::DONE_BIT] = 1'b1; // see [R13]
        if (st_reg.config_reg[converter_pkg::WINDOW_MODE_BIT] ?
          out_window : in_window)
          st_next.control_reg[converter_pkg::WINDOW_BIT] = 1'b1; // see [R11] [R12] [R13]
      end
      default: st_next.phase = IDLE;
    endcase
    // Clearing enable stops at once, also in the writing cycle; see [R7]
    if (!st_next.control_reg[converter_pkg::ENABLE_BIT] && st_next.phase != IDLE)
    begin
      st_next.phase = IDLE;
      st_next.control_reg[converter_pkg::ACTIVE_BIT] = 1'b0;
    end
  end

  // Window test on the stored result word
  always_comb
  begin
    in_window = st_reg.result_reg > st_reg.lower_reg &&
      st_reg.result_reg < st_reg.upper_reg; // see [R11]
    out_window = st_reg.result_reg < st_reg.lower_reg ||
      st_reg.result_reg > st_reg.upper_reg; // see [R12]
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_reg <= '0;
      st_reg.phase <= IDLE;
      st_reg.control_reg <= converter_pkg::CONTROL_RESET;
      st_reg.config_reg <= converter_pkg::CONFIG_RESET;
      st_reg.lower_reg <= converter_pkg::LOWER_RESET;
      st_reg.upper_reg <= converter_pkg::UPPER_RESET;
    end
    else
      st_reg <= st_next;
  end

  assign sfr_rdata = st_reg.rdata_reg;
  assign converter_powered = st_reg.control_reg[converter_pkg::ENABLE_BIT]; // see [R7]
  assign burst_clock_select = st_reg.control_reg[converter_pkg::BURST_BIT]; // see [R8] [R9]
  assign sample_hold = st_reg.phase == CONVERT;
  assign window_match_flag = st_reg.control_reg[converter_pkg::WINDOW_BIT];
  assign conversion_done_flag = st_reg.control_reg[converter_pkg::DONE_BIT];
endmodule // converter_ctrl

// File: rtl/converter_pkg.sv
// Constants for the converter control and result block.
// Assumes an 8-bit special-function register port on the system clock.
package converter_pkg;
  // Register addresses; control is fixed, the others are local choices
  localparam logic [7:0] CONTROL_ADDR = 8'hE8;
  localparam logic [7:0] CONFIG_ADDR = 8'hBC;
  localparam logic [7:0] RESULT_HI_ADDR = 8'hBE;
  localparam logic [7:0] RESULT_LO_ADDR = 8'hBD;
  localparam logic [7:0] LOWER_HI_ADDR = 8'hC4;
  localparam logic [7:0] LOWER_LO_ADDR = 8'hC3;
  localparam logic [7:0] UPPER_HI_ADDR = 8'hC6;
  localparam logic [7:0] UPPER_LO_ADDR = 8'hC5;
  // Control bit positions
  localparam int ENABLE_BIT = 7;
  localparam int BURST_BIT = 6;
  localparam int DONE_BIT = 5;
  localparam int ACTIVE_BIT = 4;
  localparam int WINDOW_BIT = 3;
  localparam int JUSTIFY_BIT = 2;
  // Config fields: repeat in [1:0], window mode in bit 2
  localparam int WINDOW_MODE_BIT = 2;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [15:0] LOWER_RESET = 16'h0000;
  localparam logic [15:0] UPPER_RESET = 16'hFFFF;
  // Start sources
  localparam logic [1:0] START_WRITE = 2'h0;
  localparam logic [1:0] START_TIMER3 = 2'h1;
  localparam logic [1:0] START_PIN = 2'h2;
  localparam logic [1:0] START_TIMER2 = 2'h3;
  // Repeat encodings: 1, 4, 8, 16
  localparam logic [1:0] REPEAT_1 = 2'h0;
  localparam logic [1:0] REPEAT_4 = 2'h1;
  localparam logic [1:0] REPEAT_8 = 2'h2;
  // Conversion timing
  localparam int SAR_PERIODS = 13;
  localparam int EXTRA_CYCLES = 2;
  localparam int SAR_DIVIDE = 4;
  localparam int CONVERT_CYCLES = SAR_PERIODS * SAR_DIVIDE + EXTRA_CYCLES;
  localparam real BURST_MAX_MHZ = 25.0;
endpackage

// File: rtl/sample_sum.sv
// Accumulator for a series of converter samples.
// Assumes samples arrive on the system clock with a one-cycle strobe.
`timescale 1ns/100ps
module sample_sum (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clear,
  input wire logic add,
  input wire logic [11:0] sample,
  output logic [15:0] sum
);
  typedef struct packed {
    logic [15:0] sum_reg;
  } sum_state_t;
  sum_state_t st_reg;
  sum_state_t st_next;

  always_comb
  begin
    st_next = st_reg;
    if (clear)
      st_next.sum_reg = 16'h0000;
    else if (add)
      st_next.sum_reg = st_reg.sum_reg + {4'h0, sample};
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign sum = st_reg.sum_reg;
endmodule // sample_sum
